/* File: shared/sdm_pkg.sv */
// package: constants and types for the segment descriptor matcher
package sdm_pkg;

	// ****************************************************************
	// sizes
	// ****************************************************************
	localparam int SDM_NUM_DESC  = 32;
	localparam int SDM_TABLE_DEPTH = 16;
	localparam int SDM_ACC_BYTES = 9;
	localparam int SDM_DP_W      = 5;

	// ****************************************************************
	// system register offsets (byte wide port)
	// ****************************************************************
	localparam logic [5:0] SDM_OFS_TABLE = 6'h00;
	localparam logic [5:0] SDM_OFS_ACC   = 6'h10;
	localparam logic [5:0] SDM_OFS_GSR   = 6'h19;
	localparam logic [5:0] SDM_OFS_DP    = 6'h1A;
	localparam logic [5:0] SDM_OFS_OP    = 6'h1B;
	localparam logic [5:0] SDM_OFS_FLAGS = 6'h1C;
	localparam logic [5:0] SDM_OFS_LSR   = 6'h1D;

	// ****************************************************************
	// accumulator byte slots
	// ****************************************************************
	localparam int SDM_ACC_BASE_HI = 0;
	localparam int SDM_ACC_BASE_LO = 1;
	localparam int SDM_ACC_MASK_HI = 2;
	localparam int SDM_ACC_MASK_LO = 3;
	localparam int SDM_ACC_PHYS_HI = 4;
	localparam int SDM_ACC_PHYS_LO = 5;
	localparam int SDM_ACC_SPACE   = 6;
	localparam int SDM_ACC_FLAGS   = 7;
	localparam int SDM_ACC_SMASK   = 8;

	// ****************************************************************
	// operation codes and bit positions
	// ****************************************************************
	localparam logic [7:0] SDM_OP_LOAD       = 8'h01;
	localparam logic [7:0] SDM_OP_READ       = 8'h02;
	localparam int         SDM_GSR_GATE_BIT  = 0;
	localparam int         SDM_LSR_LIP_BIT   = 0;
	localparam int         SDM_LSR_FAIL_BIT  = 1;
	localparam int         SDM_LSR_BUSY_BIT  = 2;
	localparam logic [7:0] SDM_FLAG_WR_MASK  = 8'h9F;
	localparam logic [7:0] SDM_FLAGS_MASTER  = 8'h01;
	localparam logic [7:0] SDM_FLAGS_OTHER   = 8'h00;
	localparam logic [7:0] SDM_BYTE_ZERO     = 8'h00;

	// ****************************************************************
	// types
	// ****************************************************************
	typedef struct packed {
		logic        used;
		logic [1:0]  rsvd;
		logic        irq_on_access;
		logic        interrupt_pending;
		logic        modified;
		logic        write_protect;
		logic        enable;
	} sdm_flags_t;

	typedef struct packed {
		logic [15:0] segment_logical_base;
		logic [15:0] segment_logical_mask;
		logic [15:0] segment_physical_base;
		logic [7:0]  segment_space_number;
		logic [7:0]  segment_space_mask;
	} sdm_desc_t;

	typedef struct packed {
		logic        valid;
		logic        write;
		logic [3:0]  fc;
		logic [15:0] la_hi;
		logic [6:0]  la_lo;
	} sdm_xlat_req_t;

	typedef struct packed {
		logic        done;
		logic        fault;
		logic        wr_violation;
		logic [22:0] pa;
	} sdm_xlat_rsp_t;

	typedef enum logic [1:0] {
		SDM_ST_IDLE = 2'b00,
		SDM_ST_EXEC = 2'b01,
		SDM_ST_DONE = 2'b11
	} sdm_op_state_t;

endpackage : sdm_pkg

/* File: core/sdm_descriptor.sv */
// one segment descriptor: storage, match and status flags
`timescale 1ns/1ps
`default_nettype none
module sdm_descriptor #(
	parameter bit MASTER_ZERO = 1'b0
) (
	input  wire logic               clk,
	input  wire logic               rst_n,
	input  wire logic               load,
	input  wire sdm_pkg::sdm_desc_t load_data,
	input  wire logic [7:0]         load_flags,
	input  wire logic               load_ok,
	input  wire logic               flag_wr,
	input  wire logic [7:0]         flag_wdata,
	input  wire logic [7:0]         cyc_space,
	input  wire logic [15:0]        log_addr,
	input  wire logic               access,
	input  wire logic               acc_write,
	output logic                    hit,
	output logic [15:0]             phys_hi,
	output sdm_pkg::sdm_desc_t      desc,
	output sdm_pkg::sdm_flags_t     flags
);
	import sdm_pkg::*;

	sdm_desc_t  next_desc;
	sdm_flags_t next_flags;

	// ****************************************************************
	// match and physical address
	// ****************************************************************
	always_comb begin
		hit = flags.enable &&
			(((desc.segment_logical_base ^ log_addr) &
			desc.segment_logical_mask) == 16'h0000) &&
			(((desc.segment_space_number ^ cyc_space) &
			desc.segment_space_mask) == 8'h00);
		phys_hi = (desc.segment_physical_base & desc.segment_logical_mask) |
			(log_addr & ~desc.segment_logical_mask);
	end

	// ****************************************************************
	// next state
	// ****************************************************************
	always_comb begin
		next_desc  = desc;
		next_flags = flags;
		if (load) begin
			next_desc  = load_data;
			next_flags = sdm_flags_t'(load_flags & SDM_FLAG_WR_MASK);
			next_flags.enable = load_flags[0] && load_ok;
		end else if (flag_wr) begin
			next_flags = sdm_flags_t'(flag_wdata & SDM_FLAG_WR_MASK);
			next_flags.enable = flags.enable && flag_wdata[0];
		end
		if (access) begin
			next_flags.used = 1'b1;
			if (flags.irq_on_access)
				next_flags.interrupt_pending = 1'b1;
			if (acc_write && !flags.write_protect)
				next_flags.modified = 1'b1;
		end
		if (!next_flags.enable)
			next_flags.interrupt_pending = 1'b0;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			if (MASTER_ZERO) begin
				desc  <= '0;
				flags <= sdm_flags_t'(SDM_FLAGS_MASTER);
			end else begin
				flags <= sdm_flags_t'(SDM_FLAGS_OTHER);
			end
		end else begin
			desc  <= next_desc;
			flags <= next_flags;
		end
	end

	// ****************************************************************
	// checks
	// ****************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_used_on_access: assert property (access |=> flags.used)
		else $error("used flag not set after access");
	a_enable_never_set: assert property (
		(!load && !flags.enable) |=> !flags.enable)
		else $error("enable set without load");
	a_pending_needs_en: assert property (
		!flags.enable |-> !flags.interrupt_pending)
		else $error("pending left set on disabled segment");

endmodule : sdm_descriptor
`default_nettype wire

/* File: core/segment_descriptor_matcher.sv */
// segment descriptor matcher: system registers, translation, irq
// Operation
// - thirty-two descriptors, nine bytes, one segment each
// - control and alterable bits read and write
// - unalterable and reserved bits ignore writes
// - descriptors reached only via pointer and accumulator
// - load operation and indirect status write
// - logical range match under logical mask
// - physical base substituted where mask is one
// - space number match under space mask
// - matched translation counts as segment access
// - status byte: used bit7, enable bit0
// - used set by access or write one
// - access with interrupt bit sets pending
// - irq while any pending and gate set
// - pending cleared by write zero or disable
// - modified set by successful write access
// - write to protected segment is violation
// - only enabled segments match; writes cannot enable
// - load copies status byte bit0 to enable when the mask is legal
// - reset initialises descriptor zero, clears status of all others
// - unmatched access raises fault
// - upper sixteen bits translated, low seven pass
// - function code indexes sixteen entry space table
`timescale 1ns/1ps
`default_nettype none
module segment_descriptor_matcher #(
	parameter int NUM_DESC = sdm_pkg::SDM_NUM_DESC
) (
	input  wire logic                  clk,
	input  wire logic                  rst_n,
	input  wire logic                  sys_sel,
	input  wire logic                  sys_write,
	input  wire logic [5:0]            sys_addr,
	input  wire logic [7:0]            sys_wdata,
	output logic [7:0]                 sys_rdata,
	input  wire sdm_pkg::sdm_xlat_req_t xlat_req,
	output sdm_pkg::sdm_xlat_rsp_t     xlat_rsp,
	output logic                       irq_request_pin
);
	import sdm_pkg::*;

	if (NUM_DESC < 2 || NUM_DESC > (1 << SDM_DP_W)) begin : g_chk
		$error("NUM_DESC out of range");
	end

	// ****************************************************************
	// state
	// ****************************************************************
	logic [7:0]    space_lookup_table [SDM_TABLE_DEPTH];
	logic [7:0]    next_table [SDM_TABLE_DEPTH];
	logic [7:0]    acc [SDM_ACC_BYTES];
	logic [7:0]    next_acc [SDM_ACC_BYTES];
	logic          irq_global_gate;
	logic          next_gate;
	logic [SDM_DP_W-1:0] dp;
	logic [SDM_DP_W-1:0] next_dp;
	sdm_op_state_t op_state;
	sdm_op_state_t next_op_state;
	logic [7:0]    op_code;
	logic [7:0]    next_op_code;
	logic          load_fail;
	logic          next_load_fail;
	logic [7:0]    next_rdata;
	sdm_xlat_rsp_t next_rsp;

	// ****************************************************************
	// descriptor array
	// ****************************************************************
	sdm_desc_t     desc_q   [NUM_DESC];
	sdm_flags_t    flags_q  [NUM_DESC];
	logic [15:0]   pa_hi    [NUM_DESC];
	logic [NUM_DESC-1:0] hit;
	logic [NUM_DESC-1:0] grant;
	logic [NUM_DESC-1:0] pend_vec;
	sdm_desc_t     load_desc;
	logic          load_ok;
	logic          do_load;
	logic          do_read;
	logic          flags_wr;
	logic [15:0]   inv_mask;
	logic [7:0]    cyc_space;
	logic [15:0]   phys_sel;
	logic          wp_sel;
	logic          any_hit;
	logic [3:0]    acc_idx;
	logic          acc_hit;
	sdm_desc_t     rd_desc;
	sdm_flags_t    rd_flags;

	always_comb begin
		load_desc.segment_logical_base  =
			{acc[SDM_ACC_BASE_HI], acc[SDM_ACC_BASE_LO]};
		load_desc.segment_logical_mask  =
			{acc[SDM_ACC_MASK_HI], acc[SDM_ACC_MASK_LO]};
		load_desc.segment_physical_base =
			{acc[SDM_ACC_PHYS_HI], acc[SDM_ACC_PHYS_LO]};
		load_desc.segment_space_number  = acc[SDM_ACC_SPACE];
		load_desc.segment_space_mask    = acc[SDM_ACC_SMASK];
		// a mask must be ones from the top down to be a legal size
		inv_mask = ~load_desc.segment_logical_mask;
		load_ok  = ((inv_mask & (inv_mask + 16'h0001)) == 16'h0000);
		do_load  = (op_state == SDM_ST_EXEC) && (op_code == SDM_OP_LOAD);
		do_read  = (op_state == SDM_ST_EXEC) && (op_code == SDM_OP_READ);
		flags_wr = sys_sel && sys_write && (sys_addr == SDM_OFS_FLAGS);
		cyc_space = space_lookup_table[xlat_req.fc];
	end

	for (genvar i = 0; i < NUM_DESC; i++) begin : g_desc
		sdm_descriptor #(
			.MASTER_ZERO (i == 0)
		) u_desc (
			.clk        (clk),
			.rst_n      (rst_n),
			.load       (do_load && (dp == SDM_DP_W'(i))),
			.load_data  (load_desc),
			.load_flags (acc[SDM_ACC_FLAGS]),
			.load_ok    (load_ok),
			.flag_wr    (flags_wr && (dp == SDM_DP_W'(i))),
			.flag_wdata (sys_wdata),
			.cyc_space  (cyc_space),
			.log_addr   (xlat_req.la_hi),
			.access     (grant[i]),
			.acc_write  (xlat_req.write),
			.hit        (hit[i]),
			.phys_hi    (pa_hi[i]),
			.desc       (desc_q[i]),
			.flags      (flags_q[i])
		);
		assign pend_vec[i] = flags_q[i].interrupt_pending;
	end

	// ****************************************************************
	// priority select: lowest matching descriptor wins
	// ****************************************************************
	always_comb begin
		grant    = '0;
		any_hit  = 1'b0;
		phys_sel = xlat_req.la_hi;
		wp_sel   = 1'b0;
		for (int k = 0; k < NUM_DESC; k++) begin
			if (hit[k] && !any_hit) begin
				any_hit  = 1'b1;
				grant[k] = xlat_req.valid;
				phys_sel = pa_hi[k];
				wp_sel   = flags_q[k].write_protect;
			end
		end
	end

	// ****************************************************************
	// translation response
	// ****************************************************************
	always_comb begin
		next_rsp.done         = xlat_req.valid;
		next_rsp.fault        = xlat_req.valid && !any_hit;
		next_rsp.wr_violation = xlat_req.valid && any_hit &&
			xlat_req.write && wp_sel;
		next_rsp.pa           = {phys_sel, xlat_req.la_lo};
	end

	always_ff @(posedge clk) begin
		if (!rst_n)
			xlat_rsp <= '0;
		else
			xlat_rsp <= next_rsp;
	end

	assign irq_request_pin = irq_global_gate && (|pend_vec);

	// ****************************************************************
	// system registers and operations
	// ****************************************************************
	always_comb begin
		acc_idx  = 4'(sys_addr - SDM_OFS_ACC);
		acc_hit  = (sys_addr >= SDM_OFS_ACC) &&
			(sys_addr < SDM_OFS_ACC + 6'(SDM_ACC_BYTES));
		rd_desc  = desc_q[dp];
		rd_flags = flags_q[dp];
		next_table    = space_lookup_table;
		next_acc      = acc;
		next_gate     = irq_global_gate;
		next_dp       = dp;
		next_op_code  = op_code;
		next_op_state = op_state;
		next_load_fail = load_fail;
		next_rdata    = SDM_BYTE_ZERO;
		case (op_state)
			SDM_ST_IDLE: begin
				if (sys_sel && sys_write && sys_addr == SDM_OFS_OP &&
					(sys_wdata == SDM_OP_LOAD || sys_wdata == SDM_OP_READ)) begin
					next_op_code  = sys_wdata;
					next_op_state = SDM_ST_EXEC;
				end
			end
			SDM_ST_EXEC: begin
				next_op_state = SDM_ST_DONE;
			end
			SDM_ST_DONE: begin
				next_op_state = SDM_ST_IDLE;
			end
			default: begin
				next_op_state = SDM_ST_IDLE;
			end
		endcase
		// a fault latches the failing address and space for software
		if (next_rsp.fault) begin
			next_acc[SDM_ACC_BASE_HI] = xlat_req.la_hi[15:8];
			next_acc[SDM_ACC_BASE_LO] = xlat_req.la_hi[7:0];
			next_acc[SDM_ACC_SPACE]   = cyc_space;
		end
		if (do_load) begin
			next_load_fail = !load_ok;
		end
		if (do_read) begin
			next_acc[SDM_ACC_BASE_HI] = rd_desc.segment_logical_base[15:8];
			next_acc[SDM_ACC_BASE_LO] = rd_desc.segment_logical_base[7:0];
			next_acc[SDM_ACC_MASK_HI] = rd_desc.segment_logical_mask[15:8];
			next_acc[SDM_ACC_MASK_LO] = rd_desc.segment_logical_mask[7:0];
			next_acc[SDM_ACC_PHYS_HI] = rd_desc.segment_physical_base[15:8];
			next_acc[SDM_ACC_PHYS_LO] = rd_desc.segment_physical_base[7:0];
			next_acc[SDM_ACC_SPACE]   = rd_desc.segment_space_number;
			next_acc[SDM_ACC_FLAGS]   = rd_flags & SDM_FLAG_WR_MASK;
			next_acc[SDM_ACC_SMASK]   = rd_desc.segment_space_mask;
		end
		if (sys_sel && sys_write) begin
			if (sys_addr < SDM_OFS_ACC)
				next_table[sys_addr[3:0]] = sys_wdata;
			else if (acc_hit)
				next_acc[acc_idx] = sys_wdata;
			else if (sys_addr == SDM_OFS_GSR)
				next_gate = sys_wdata[SDM_GSR_GATE_BIT];
			else if (sys_addr == SDM_OFS_DP)
				next_dp = sys_wdata[SDM_DP_W-1:0];
		end
		if (sys_sel && !sys_write) begin
			if (sys_addr < SDM_OFS_ACC)
				next_rdata = space_lookup_table[sys_addr[3:0]];
			else if (acc_hit)
				next_rdata = acc[acc_idx];
			else if (sys_addr == SDM_OFS_GSR)
				next_rdata[SDM_GSR_GATE_BIT] = irq_global_gate;
			else if (sys_addr == SDM_OFS_DP)
				next_rdata[SDM_DP_W-1:0] = dp;
			else if (sys_addr == SDM_OFS_FLAGS)
				next_rdata = rd_flags & SDM_FLAG_WR_MASK;
			else if (sys_addr == SDM_OFS_LSR) begin
				next_rdata[SDM_LSR_LIP_BIT]  = |pend_vec;
				next_rdata[SDM_LSR_FAIL_BIT] = load_fail;
				next_rdata[SDM_LSR_BUSY_BIT] = (op_state != SDM_ST_IDLE);
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			for (int a = 0; a < SDM_TABLE_DEPTH; a++)
				space_lookup_table[a] <= SDM_BYTE_ZERO;
			for (int b = 0; b < SDM_ACC_BYTES; b++)
				acc[b] <= SDM_BYTE_ZERO;
			irq_global_gate <= 1'b0;
			dp        <= '0;
			op_state  <= SDM_ST_IDLE;
			op_code   <= SDM_BYTE_ZERO;
			load_fail <= 1'b0;
			sys_rdata <= SDM_BYTE_ZERO;
		end else begin
			space_lookup_table <= next_table;
			acc        <= next_acc;
			irq_global_gate <= next_gate;
			dp        <= next_dp;
			op_state  <= next_op_state;
			op_code   <= next_op_code;
			load_fail <= next_load_fail;
			sys_rdata <= next_rdata;
		end
	end

	// ****************************************************************
	// checks
	// ****************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_load_start;
		op_state == SDM_ST_EXEC && op_code == SDM_OP_LOAD;
	endsequence
	sequence s_op_finish;
		op_state == SDM_ST_DONE ##1 op_state == SDM_ST_IDLE;
	endsequence

	a_load_sequence: assert property (s_load_start |=> s_op_finish)
		else $error("load operation did not finish in two cycles");
	a_fault_on_miss: assert property (
		(xlat_req.valid && hit == '0) |=> (xlat_rsp.fault && xlat_rsp.done))
		else $error("unmatched access gave no fault");
	a_wp_violation: assert property (
		(xlat_req.valid && any_hit && xlat_req.write && wp_sel)
		|=> xlat_rsp.wr_violation && !xlat_rsp.fault)
		else $error("protected write not flagged");
	a_low_bits_pass: assert property (
		xlat_req.valid |=> xlat_rsp.pa[6:0] == $past(xlat_req.la_lo))
		else $error("low address bits altered");
	a_phys_translate: assert property (
		(xlat_req.valid && any_hit) |=> xlat_rsp.pa[22:7] == $past(phys_sel))
		else $error("physical address mismatch");
	a_irq_gate_off: assert property (
		$fell(irq_global_gate) |-> !irq_request_pin)
		else $error("irq stays with gate cleared");
	a_reserved_zero: assert property (
		(sys_sel && !sys_write && sys_addr == SDM_OFS_FLAGS)
		|=> sys_rdata[6:5] == 2'b00)
		else $error("reserved status bits read nonzero");

endmodule : segment_descriptor_matcher
`default_nettype wire

/* File: verification/sdm_bus_master.sv */
// bus master model issuing translated cycles
`timescale 1ns/1ps
`default_nettype none
module sdm_bus_master (
	input  wire logic                   clk,
	output var sdm_pkg::sdm_xlat_req_t  xlat_req,
	input  wire sdm_pkg::sdm_xlat_rsp_t xlat_rsp
);
	import sdm_pkg::*;

	initial begin
		xlat_req = '0;
	end

	// ****************************************************************
	// one request cycle, answer taken one cycle later
	// ****************************************************************
	task automatic cycle(
		input  logic          wr,
		input  logic [3:0]    fc,
		input  logic [15:0]   la,
		input  logic [6:0]    lo,
		output sdm_xlat_rsp_t rsp
	);
		@(negedge clk);
		xlat_req <= {1'b1, wr, fc, la, lo};
		@(negedge clk);
		rsp = xlat_rsp;
		xlat_req <= {1'b0, ~wr, ~fc, ~la, ~lo};
	endtask : cycle
endmodule : sdm_bus_master
`default_nettype wire

/* File: verification/segment_descriptor_matcher_test.sv */
// self-checking testbench for the segment descriptor matcher
`timescale 1ns/1ps
`default_nettype none
module segment_descriptor_matcher_test;
	import sdm_pkg::*;

	logic          clk;
	logic          rst_n;
	logic          sys_sel;
	logic          sys_write;
	logic [5:0]    sys_addr;
	logic [7:0]    sys_wdata;
	logic [7:0]    sys_rdata;
	sdm_xlat_req_t xlat_req;
	sdm_xlat_rsp_t xlat_rsp;
	logic          irq_request_pin;
	int            n_fail;
	int            compares;
	int            cycles;

	segment_descriptor_matcher segment_descriptor_matcher_inst (
		.clk            (clk),
		.rst_n          (rst_n),
		.sys_sel        (sys_sel),
		.sys_write      (sys_write),
		.sys_addr       (sys_addr),
		.sys_wdata      (sys_wdata),
		.sys_rdata      (sys_rdata),
		.xlat_req       (xlat_req),
		.xlat_rsp       (xlat_rsp),
		.irq_request_pin(irq_request_pin)
	);

	sdm_bus_master sdm_bus_master_inst (
		.clk     (clk),
		.xlat_req(xlat_req),
		.xlat_rsp(xlat_rsp)
	);

	// ****************************************************************
	// clock, timeout and verdict
	// ****************************************************************
	always #25 clk = ~clk;

	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			n_fail++;
			give_verdict();
		end
	end

	task automatic give_verdict();
		if (n_fail == 0 && compares > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : give_verdict

	// ****************************************************************
	// access tasks
	// ****************************************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
		input string m);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR %0t %s got %0h exp %0h", $time, m, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		@(negedge clk);
		sys_sel   <= 1'b1;
		sys_write <= 1'b1;
		sys_addr  <= a;
		sys_wdata <= d;
		@(negedge clk);
		sys_sel   <= 1'b0;
		sys_wdata <= ~d;
	endtask : wr

	task automatic rd(input logic [5:0] a, input logic [7:0] e,
		input string m);
		@(negedge clk);
		sys_sel   <= 1'b1;
		sys_write <= 1'b0;
		sys_addr  <= a;
		@(negedge clk);
		sys_sel   <= 1'b0;
		chk({24'h0, sys_rdata}, {24'h0, e}, m);
	endtask : rd

	task automatic xl(input logic w, input logic [3:0] fc,
		input logic [15:0] la, input logic [6:0] lo, input logic f,
		input logic v, input logic [22:0] pa, input string m);
		sdm_xlat_rsp_t r;
		sdm_bus_master_inst.cycle(w, fc, la, lo, r);
		chk({r.done, r.fault, r.wr_violation, r.pa}, {1'b1, f, v, pa}, m);
	endtask : xl

	task automatic ld(input logic [7:0] dp, input logic [71:0] v);
		for (int i = 0; i < SDM_ACC_BYTES; i++) begin
			wr(SDM_OFS_ACC + 6'(i), v[71 - 8 * i -: 8]);
		end
		wr(SDM_OFS_DP, dp);
		wr(SDM_OFS_OP, SDM_OP_LOAD);
		repeat (4) @(negedge clk);
	endtask : ld

	task automatic irq(input logic e, input string m);
		chk({31'h0, irq_request_pin}, {31'h0, e}, m);
	endtask : irq

	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial begin
		clk = 1'b0;
		rst_n = 1'b0;
		sys_sel = 1'b0;
		sys_write = 1'b0;
		sys_addr = 6'h00;
		sys_wdata = 8'h00;
		n_fail = 0;
		compares = 0;
		cycles = 0;
		repeat (20) @(negedge clk);
		rst_n <= 1'b1;
		rd(SDM_OFS_FLAGS, 8'h01, "reset flags");
		rd(SDM_OFS_LSR, 8'h00, "reset lsr");
		irq(1'b0, "reset irq");
		xl(0, 4'h1, 16'h5A3C, 7'h2B, 0, 0, {16'h5A3C, 7'h2B}, "id");
		rd(SDM_OFS_FLAGS, 8'h81, "used d0");
		wr(SDM_OFS_FLAGS, 8'h00);
		wr(SDM_OFS_FLAGS, 8'h01);
		rd(SDM_OFS_FLAGS, 8'h00, "no enable");
		xl(0, 4'h1, 16'h5A3C, 7'h2B, 1, 0, {16'h5A3C, 7'h2B}, "off");
		ld(1, {16'h1200, 16'hFF00, 16'hAB00, 8'h05, 8'h11, 8'h0F});
		wr(SDM_OFS_TABLE + 6'h02, 8'h15);
		wr(SDM_OFS_TABLE + 6'h03, 8'h06);
		rd(SDM_OFS_TABLE + 6'h02, 8'h15, "table");
		wr(SDM_OFS_DP, 8'h01);
		rd(SDM_OFS_DP, 8'h01, "pointer");
		rd(SDM_OFS_FLAGS, 8'h11, "load flags");
		xl(0, 4'h2, 16'h12AB, 7'h55, 0, 0, {16'hABAB, 7'h55}, "hit");
		rd(SDM_OFS_FLAGS, 8'h99, "access");
		irq(1'b0, "gate off");
		wr(SDM_OFS_GSR, 8'h01);
		rd(SDM_OFS_GSR, 8'h01, "gate");
		irq(1'b1, "gate on");
		rd(SDM_OFS_LSR, 8'h01, "lsr pend");
		wr(SDM_OFS_FLAGS, 8'h91);
		irq(1'b0, "pend clr");
		xl(1, 4'h2, 16'h12AB, 7'h55, 0, 0, {16'hABAB, 7'h55}, "wr");
		rd(SDM_OFS_FLAGS, 8'h9D, "modified");
		irq(1'b1, "pend again");
		wr(SDM_OFS_FLAGS, 8'h63);
		rd(SDM_OFS_FLAGS, 8'h03, "rsvd");
		irq(1'b0, "pend wr0");
		wr(SDM_OFS_FLAGS, 8'h0B);
		irq(1'b1, "pend wr1");
		wr(SDM_OFS_FLAGS, 8'h03);
		xl(1, 4'h2, 16'h12AB, 7'h55, 0, 1, {16'hABAB, 7'h55}, "wp");
		rd(SDM_OFS_FLAGS, 8'h83, "wp flags");
		xl(0, 4'h2, 16'h13AB, 7'h55, 1, 0, {16'h13AB, 7'h55}, "rng");
		xl(0, 4'h3, 16'h12AB, 7'h55, 1, 0, {16'h12AB, 7'h55}, "spc");
		rd(SDM_OFS_ACC, 8'h12, "fault addr");
		rd(SDM_OFS_ACC + 6'h06, 8'h06, "fault space");
		ld(31, {16'h4000, 16'hC000, 16'h8000, 8'h00, 8'h01, 8'h00});
		rd(SDM_OFS_FLAGS, 8'h01, "d31");
		xl(0, 4'h0, 16'h7F12, 7'h01, 0, 0, {16'hBF12, 7'h01}, "d31");
		ld(31, {16'h4000, 16'hF0F0, 16'h8000, 8'h00, 8'h01, 8'h00});
		rd(SDM_OFS_FLAGS, 8'h00, "bad load");
		rd(SDM_OFS_LSR, 8'h02, "fail bit");
		ld(31, {16'h4000, 16'hC000, 16'h8000, 8'h00, 8'h00, 8'h00});
		rd(SDM_OFS_FLAGS, 8'h00, "status off");
		wr(SDM_OFS_DP, 8'h01);
		wr(SDM_OFS_OP, SDM_OP_READ);
		repeat (4) @(negedge clk);
		rd(SDM_OFS_ACC + 6'h02, 8'hFF, "rd mask");
		rd(SDM_OFS_ACC + 6'h04, 8'hAB, "rd phys");
		rd(SDM_OFS_ACC + 6'h08, 8'h0F, "rd smask");
		wr(SDM_OFS_FLAGS, 8'h08);
		rd(SDM_OFS_FLAGS, 8'h00, "pend dis");
		irq(1'b0, "pend dis irq");
		rd(6'h3F, 8'h00, "unmapped");
		wr(SDM_OFS_LSR, 8'hFF);
		rd(SDM_OFS_LSR, 8'h00, "lsr ro");
		give_verdict();
	end
endmodule : segment_descriptor_matcher_test
`default_nettype wire
